// ===== hw/ppm_defines.svh
// Register offsets, bit positions, reset values and time bases of the panel power manager
`ifndef PPM_DEFINES_SVH
`define PPM_DEFINES_SVH

// I/O ports of the extended sequencer index and data
`define PPM_PORT_INDEX     16'h03c4
`define PPM_PORT_DATA      16'h03c5

// Extended sequencer indexes
`define PPM_IDX_MODE_CTRL  8'hd2
`define PPM_IDX_TIMERS     8'hd3
`define PPM_IDX_ACTIVITY   8'hd4
`define PPM_IDX_OFF_TIMER  8'hd5

// Reset values
`define PPM_RST_INDEX      8'h00
`define PPM_RST_MODE_CTRL  8'h00
`define PPM_RST_TIMERS     8'h00
`define PPM_RST_ACTIVITY   8'h00
`define PPM_RST_OFF_TIMER  8'h00

// power_mode_control bits
`define PPM_B_PIN_IN       1
`define PPM_B_PIN_POL      2
`define PPM_B_TGT_SUSP     3
`define PPM_B_F_STBY       4
`define PPM_B_F_SUSP       5
`define PPM_B_F_OFF        6
`define PPM_B_COVER        7

// backlight_and_idle_timers fields
`define PPM_F_BL           3:0
`define PPM_F_IDLE         7:4

// activity_monitor_enables bits
`define PPM_B_ACC_BL       0
`define PPM_B_KBD_BL       1
`define PPM_B_ACC_IDLE     4
`define PPM_B_KBD_IDLE     5

// off_timer_refresh_control fields
`define PPM_F_OFF          3:0
`define PPM_B_SLOW_EN      4
`define PPM_F_RATE         6:5
`define PPM_B_CLK_EXT      7

// Time bases: timers advance in sixteenths of a minute
`define PPM_REF_HZ         14318000
`define PPM_REF_PREDIV     4
`define PPM_EXT_HZ         32000
`define PPM_SEC_PER_MIN    60
`define PPM_SUB_PER_MIN    16
`define PPM_BL_UNIT_MIN    1
`define PPM_IDLE_UNIT_MIN  2
`define PPM_OFF_UNIT_MIN   4
`define PPM_REF_DIV        ((`PPM_REF_HZ / `PPM_REF_PREDIV) * `PPM_SEC_PER_MIN / `PPM_SUB_PER_MIN)
`define PPM_EXT_DIV        (`PPM_EXT_HZ * `PPM_SEC_PER_MIN / `PPM_SUB_PER_MIN)
`define PPM_BL_SUBS        (`PPM_BL_UNIT_MIN * `PPM_SUB_PER_MIN)
`define PPM_IDLE_SUBS      (`PPM_IDLE_UNIT_MIN * `PPM_SUB_PER_MIN)
`define PPM_OFF_SUBS       (`PPM_OFF_UNIT_MIN * `PPM_SUB_PER_MIN)

`endif

// ===== hw/ppm_pkg.sv
// Types and shared arithmetic of the panel power manager
package ppm_pkg;

	// Display power modes
	typedef enum logic [2:0] {
		PPM_ACTIVE,
		PPM_STANDBY,
		PPM_SUSPEND,
		PPM_OFF,
		PPM_COVER
	} ppm_mode_type;

	// One host I/O cycle
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} ppm_io_req_type;

	// Panel and CRT power controls
	typedef struct packed {
		logic logic_down;
		logic crt_on;
		logic slow_refresh;
		logic [1:0] refresh_rate;
	} ppm_panel_ctl_type;

	// Elapsed count at which a timer setting expires
	function automatic logic [9:0] ppm_limit(input logic [3:0] setting, input logic [9:0] unit);
		ppm_limit = {6'h00, setting} * unit;
	endfunction

endpackage

// ===== hw/ppm_timebase.sv
// Time base: reference divided by four, or external 32 kHz, down to sixteenth-minute ticks
`timescale 1ns/1ps
`include "ppm_defines.svh"
module ppm_timebase
	import ppm_pkg::*;
#(
	parameter int DIV_REF = `PPM_REF_DIV,
	parameter int DIV_EXT = `PPM_EXT_DIV
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ref_tick,
	input  wire logic ext_clk_32k,
	input  wire logic sel_ext,
	output logic      sub_tick
);

	generate
		if (DIV_REF < 2 || DIV_EXT < 2 || DIV_REF >= 2**28 || DIV_EXT >= 2**28) begin : g_bad
			$error("ppm_timebase: divisor out of range");
		end
	endgenerate

	logic [1:0]  prediv;
	logic [27:0] cnt;
	logic        ext_prev;
	logic        base_tick;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prediv   <= 2'h0;
			ext_prev <= 1'b0;
		end else begin
			if (ref_tick)
				prediv <= prediv + 2'h1;
			ext_prev <= ext_clk_32k;
		end
	end

	always_comb begin
		if (sel_ext)
			base_tick = ext_clk_32k && !ext_prev;
		else
			base_tick = ref_tick && (prediv == 2'h3);
	end

	// Divider to sixteenth-minute ticks
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt      <= 28'h0;
			sub_tick <= 1'b0;
		end else begin
			sub_tick <= 1'b0;
			if (base_tick) begin
				if (cnt >= (sel_ext ? 28'(DIV_EXT - 1) : 28'(DIV_REF - 1))) begin
					cnt      <= 28'h0;
					sub_tick <= 1'b1;
				end else
					cnt <= cnt + 28'h1;
			end
		end
	end

endmodule

// ===== hw/ppm_timer.sv
// Inactivity timer counting sixteenth-minute ticks against a 4-bit setting
`timescale 1ns/1ps
module ppm_timer
	import ppm_pkg::*;
#(
	parameter int UNIT = 16
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       tick,
	input  wire logic       restart,
	input  wire logic [3:0] setting,
	output logic            expired
);

	generate
		if (UNIT < 1 || UNIT * 15 > 1023) begin : g_bad
			$error("ppm_timer: unit does not fit the counter");
		end
	endgenerate

	logic [9:0] elapsed;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			elapsed <= 10'h000;
		else if (restart)
			elapsed <= 10'h000;
		else if (tick && !expired)
			elapsed <= elapsed + 10'h001;
	end

	// expiry only with nonzero setting
	// Restart drops the flag at once, else a wake falls straight back asleep
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			expired <= 1'b0;
		else if (restart)
			expired <= 1'b0;
		else
			expired <= (setting != 4'h0) && (elapsed >= ppm_limit(setting, 10'(UNIT)));
	end

	property p_restart_zero;
		@(posedge clk) disable iff (!rst_n) restart |=> elapsed == 10'h000;
	endproperty
	a_restart_zero: assert property (p_restart_zero) else $error("timer not cleared by restart");

	property p_expire_needs_setting;
		@(posedge clk) disable iff (!rst_n) expired |-> $past(setting) != 4'h0;
	endproperty
	a_expire_needs_setting: assert property (p_expire_needs_setting) else $error("timer expired at zero");

endmodule

// ===== hw/ppm_power_manager.sv
// Panel power manager: indexed registers, mode sequencing, shutdown pin and backlight control
`timescale 1ns/1ps
`include "ppm_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - direction bit 1 makes shutdown pin an input, 0 an output
// - polarity bit 0 means shutdown active low, 1 active high
// - idle expiry goes to suspend when target bit set, else standby
// - writing force-standby 1 moves active mode to standby at once
// - writing force-suspend 1 enters suspend at once
// - writing force-off 1 enters off at once
// - cover-close select turns every off entry into cover-close
// - cover-close: backlight off, panel logic down, CRT keeps running
// - backlight timer is low nibble, one-minute units
// - standby/suspend timer is high nibble, two-minute units
// - zero timer setting disables that timer
// - after entering standby, backlight turns off when its time elapses
// - timers run from the reference divided by four
// - idle timer leaves active mode when idle time is reached
// - enable bit 0: graphics access restarts backlight timer
// - enable bit 1: keyboard activity restarts backlight timer
// - enable bit 4: graphics access restarts idle timer
// - enable bit 5: keyboard activity restarts idle timer
// - off timer in four-minute units moves active to off
// - clock-select bit picks divided reference or external 32 kHz
module ppm_power_manager
	import ppm_pkg::*;
#(
	parameter int DIV_REF = `PPM_REF_DIV,
	parameter int DIV_EXT = `PPM_EXT_DIV
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  ppm_io_req_type   io_req,
	output logic [7:0]       io_rdata,
	input  wire logic        gfx_access,
	input  wire logic        kbd_activity,
	input  wire logic        ref_tick,
	input  wire logic        ext_clk_32k,
	input  wire logic        off_pin_in,
	output logic             off_pin_out,
	output logic             off_pin_oe,
	output logic             panel_backlight_output,
	output ppm_panel_ctl_type panel_ctl,
	output ppm_mode_type     power_mode
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [7:0]   extended_sequencer_index;
	logic [7:0]   power_mode_control;
	logic [7:0]   backlight_and_idle_timers;
	logic [7:0]   activity_monitor_enables;
	logic [7:0]   off_timer_refresh_control;
	ppm_mode_type next_mode;
	logic         index_wr;
	logic         data_wr;
	logic         ctrl_wr;
	logic         force_stby;
	logic         force_susp;
	logic         force_off;
	logic         cover_sel;
	logic         pin_is_input;
	logic         pin_asserted;
	logic         bl_restart;
	logic         idle_restart;
	logic         sub_tick;
	logic         bl_expired;
	logic         idle_expired;
	logic         off_expired;
	logic         off_req;
	logic         susp_req;
	logic         stby_req;
	logic         next_in_off;

	////////////////////////////////////////////////////////////////////////////////
	// Host port decode

	// Index at one port, data at the next
	assign index_wr = io_req.wr && (io_req.addr == `PPM_PORT_INDEX);
	assign data_wr  = io_req.wr && (io_req.addr == `PPM_PORT_DATA);
	assign ctrl_wr  = data_wr && (extended_sequencer_index == `PPM_IDX_MODE_CTRL);

	// force standby on write of one
	assign force_stby = ctrl_wr && io_req.wdata[`PPM_B_F_STBY];
	// force suspend on write of one
	assign force_susp = ctrl_wr && io_req.wdata[`PPM_B_F_SUSP];
	// force off on write of one
	assign force_off  = ctrl_wr && io_req.wdata[`PPM_B_F_OFF];

	// New cover choice takes effect with the same write that forces off
	assign cover_sel = ctrl_wr ? io_req.wdata[`PPM_B_COVER] : power_mode_control[`PPM_B_COVER];

	// Index register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			extended_sequencer_index <= `PPM_RST_INDEX;
		else if (index_wr)
			extended_sequencer_index <= io_req.wdata;
	end

	// Data registers, written through the index
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			power_mode_control        <= `PPM_RST_MODE_CTRL;
			backlight_and_idle_timers <= `PPM_RST_TIMERS;
			activity_monitor_enables  <= `PPM_RST_ACTIVITY;
			off_timer_refresh_control <= `PPM_RST_OFF_TIMER;
		end else if (data_wr) begin
			case (extended_sequencer_index)
				`PPM_IDX_MODE_CTRL: power_mode_control        <= io_req.wdata;
				`PPM_IDX_TIMERS:    backlight_and_idle_timers <= io_req.wdata;
				`PPM_IDX_ACTIVITY:  activity_monitor_enables  <= io_req.wdata;
				`PPM_IDX_OFF_TIMER: off_timer_refresh_control <= io_req.wdata;
				default: ;
			endcase
		end
	end

	// Read data registered one cycle after the strobe; other indexes read zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			io_rdata <= 8'h00;
		else if (io_req.rd && io_req.addr == `PPM_PORT_INDEX)
			io_rdata <= extended_sequencer_index;
		else if (io_req.rd && io_req.addr == `PPM_PORT_DATA) begin
			case (extended_sequencer_index)
				`PPM_IDX_MODE_CTRL: io_rdata <= power_mode_control;
				`PPM_IDX_TIMERS:    io_rdata <= backlight_and_idle_timers;
				`PPM_IDX_ACTIVITY:  io_rdata <= activity_monitor_enables;
				`PPM_IDX_OFF_TIMER: io_rdata <= off_timer_refresh_control;
				default:            io_rdata <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shutdown pin

	assign pin_is_input = power_mode_control[`PPM_B_PIN_IN];
	// pin polarity; a driven pin never reads back as a request
	assign pin_asserted = pin_is_input && (off_pin_in == power_mode_control[`PPM_B_PIN_POL]);

	////////////////////////////////////////////////////////////////////////////////
	// Timers

	assign bl_restart = (gfx_access && activity_monitor_enables[`PPM_B_ACC_BL])
		|| (kbd_activity && activity_monitor_enables[`PPM_B_KBD_BL]);

	assign idle_restart = (gfx_access && activity_monitor_enables[`PPM_B_ACC_IDLE])
		|| (kbd_activity && activity_monitor_enables[`PPM_B_KBD_IDLE]);

	ppm_timebase #(
		.DIV_REF (DIV_REF),
		.DIV_EXT (DIV_EXT)
	) u_timebase (
		.clk         (clk),
		.rst_n       (rst_n),
		.ref_tick    (ref_tick),
		.ext_clk_32k (ext_clk_32k),
		.sel_ext     (off_timer_refresh_control[`PPM_B_CLK_EXT]),
		.sub_tick    (sub_tick)
	);

	ppm_timer #(
		.UNIT (`PPM_BL_SUBS)
	) u_bl_timer (
		.clk     (clk),
		.rst_n   (rst_n),
		.tick    (sub_tick),
		.restart (bl_restart),
		.setting (backlight_and_idle_timers[`PPM_F_BL]),
		.expired (bl_expired)
	);

	ppm_timer #(
		.UNIT (`PPM_IDLE_SUBS)
	) u_idle_timer (
		.clk     (clk),
		.rst_n   (rst_n),
		.tick    (sub_tick),
		.restart (idle_restart),
		.setting (backlight_and_idle_timers[`PPM_F_IDLE]),
		.expired (idle_expired)
	);

	// off timer shares the idle restart sources
	ppm_timer #(
		.UNIT (`PPM_OFF_SUBS)
	) u_off_timer (
		.clk     (clk),
		.rst_n   (rst_n),
		.tick    (sub_tick),
		.restart (idle_restart),
		.setting (off_timer_refresh_control[`PPM_F_OFF]),
		.expired (off_expired)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Mode sequencing

	// off timer acts only from active
	assign off_req  = pin_asserted || force_off || (power_mode == PPM_ACTIVE && off_expired);
	assign susp_req = force_susp
		|| (power_mode == PPM_ACTIVE && idle_expired && power_mode_control[`PPM_B_TGT_SUSP]);
	assign stby_req = (power_mode == PPM_ACTIVE)
		&& (force_stby || (idle_expired && !power_mode_control[`PPM_B_TGT_SUSP]));

	// Deepest request wins; enabled activity wakes back to active
	always_comb begin
		next_mode = power_mode;
		if (off_req) begin
			if (cover_sel)
				next_mode = PPM_COVER;
			else
				next_mode = PPM_OFF;
		end else if (susp_req)
			next_mode = PPM_SUSPEND;
		else if (stby_req)
			next_mode = PPM_STANDBY;
		else if (idle_restart && power_mode != PPM_ACTIVE)
			next_mode = PPM_ACTIVE;
	end

	assign next_in_off = (next_mode == PPM_OFF) || (next_mode == PPM_COVER);

	// Mode register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			power_mode <= PPM_ACTIVE;
		else
			power_mode <= next_mode;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power outputs, registered from the next mode so they line up with it

	// backlight off after its time in standby
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			panel_backlight_output <= 1'b1;
		else begin
			case (next_mode)
				PPM_ACTIVE:  panel_backlight_output <= 1'b1;
				PPM_STANDBY: panel_backlight_output <= !bl_expired;
				default:     panel_backlight_output <= 1'b0;
			endcase
		end
	end

	// panel logic down, CRT kept in cover-close
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			panel_ctl <= '{logic_down: 1'b0, crt_on: 1'b1, slow_refresh: 1'b0, refresh_rate: 2'h0};
		end else begin
			panel_ctl.logic_down   <= (next_mode == PPM_SUSPEND) || next_in_off;
			panel_ctl.crt_on       <= (next_mode != PPM_SUSPEND) && (next_mode != PPM_OFF);
			panel_ctl.slow_refresh <= (next_mode == PPM_OFF) && off_timer_refresh_control[`PPM_B_SLOW_EN];
			panel_ctl.refresh_rate <= off_timer_refresh_control[`PPM_F_RATE];
		end
	end

	// drive the pin only as an output
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			off_pin_oe  <= 1'b1;
			off_pin_out <= 1'b1;
		end else begin
			off_pin_oe  <= !pin_is_input;
			off_pin_out <= next_in_off ? power_mode_control[`PPM_B_PIN_POL]
				: !power_mode_control[`PPM_B_PIN_POL];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_pin_dir;
		##1 off_pin_oe == !$past(power_mode_control[`PPM_B_PIN_IN]);
	endproperty
	a_pin_dir: assert property (p_pin_dir) else $error("shutdown pin enable wrong");

	property p_pin_in;
		(power_mode_control[`PPM_B_PIN_IN] && !ctrl_wr
			&& off_pin_in == power_mode_control[`PPM_B_PIN_POL])
			|=> (power_mode == PPM_OFF || power_mode == PPM_COVER);
	endproperty
	a_pin_in: assert property (p_pin_in) else $error("shutdown input ignored");

	property p_idle_target;
		(power_mode == PPM_ACTIVE && idle_expired && !off_req && !force_susp)
			|=> power_mode == ($past(power_mode_control[`PPM_B_TGT_SUSP]) ? PPM_SUSPEND : PPM_STANDBY);
	endproperty
	a_idle_target: assert property (p_idle_target) else $error("idle expiry went wrong way");

	property p_force_stby;
		(power_mode == PPM_ACTIVE && force_stby && !force_susp && !force_off && !pin_asserted
			&& !off_expired && !idle_expired) |=> power_mode == PPM_STANDBY;
	endproperty
	a_force_stby: assert property (p_force_stby) else $error("forced standby missed");

	property p_force_susp;
		(force_susp && !force_off && !pin_asserted && !(power_mode == PPM_ACTIVE && off_expired))
			|=> power_mode == PPM_SUSPEND;
	endproperty
	a_force_susp: assert property (p_force_susp) else $error("forced suspend missed");

	property p_force_off;
		force_off |=> power_mode == ($past(io_req.wdata[`PPM_B_COVER]) ? PPM_COVER : PPM_OFF);
	endproperty
	a_force_off: assert property (p_force_off) else $error("forced off or cover missed");

	property p_cover_outputs;
		power_mode == PPM_COVER |-> !panel_backlight_output && panel_ctl.logic_down && panel_ctl.crt_on;
	endproperty
	a_cover_outputs: assert property (p_cover_outputs) else $error("cover-close outputs wrong");

	property p_idle_disabled;
		(backlight_and_idle_timers[`PPM_F_IDLE] == 4'h0) [*2] |-> !idle_expired;
	endproperty
	a_idle_disabled: assert property (p_idle_disabled) else $error("disabled idle timer expired");

	property p_bl_standby;
		(power_mode == PPM_STANDBY && next_mode == PPM_STANDBY && bl_expired) |=> !panel_backlight_output;
	endproperty
	a_bl_standby: assert property (p_bl_standby) else $error("backlight not off in standby");

	property p_activity_restart;
		idle_restart |=> !idle_expired ##1 !idle_expired;
	endproperty
	a_activity_restart: assert property (p_activity_restart) else $error("activity did not restart");

	c_standby: cover property (power_mode == PPM_ACTIVE ##1 power_mode == PPM_STANDBY);
	c_suspend: cover property (power_mode == PPM_ACTIVE ##1 power_mode == PPM_SUSPEND);
	c_cover:   cover property (power_mode == PPM_COVER);
	c_wake:    cover property (power_mode == PPM_STANDBY ##1 power_mode == PPM_ACTIVE);

endmodule

// ===== tb/ppm_far_model.sv
// Far-side model: reference ticks, external slow clock and the shutdown pin wire
`timescale 1ns/1ps
module ppm_far_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ext_run,
	input  wire logic drv_en,
	input  wire logic drv_lvl,
	input  wire logic off_pin_out,
	input  wire logic off_pin_oe,
	output logic      ref_tick,
	output logic      ext_clk_32k,
	output logic      off_pin_in
);
	logic [1:0] ext_cnt;

	////////////////////////////////////////////////////////////////////////////////
	// Reference pulse on every other clock, slower than real so counts stay visible
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_tick <= 1'h0;
		end else begin
			ref_tick <= !ref_tick;
		end
	end

	// External clock toggles every third cycle only while enabled, else stands still
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_cnt     <= 2'h0;
			ext_clk_32k <= 1'h0;
		end else if (ext_run) begin
			ext_cnt <= (ext_cnt == 2'h2) ? 2'h0 : ext_cnt + 2'h1;
			if (ext_cnt == 2'h2) begin
				ext_clk_32k <= !ext_clk_32k;
			end
		end
	end

	// Pin level: block output, else outside driver, else the pull-up
	assign off_pin_in = off_pin_oe ? off_pin_out : (drv_en ? drv_lvl : 1'h1);
endmodule

// ===== tb/tb_panel_power_management.sv
// Self-checking bench of the panel power manager
`timescale 1ns/1ps
module tb_panel_power_management
	import ppm_pkg::*;
;
	logic              clk;
	logic              rst_n;
	ppm_io_req_type    io_req;
	logic [7:0]        io_rdata;
	logic              gfx;
	logic              kbd;
	logic              ext_run;
	logic              drv_en;
	logic              drv_lvl;
	logic              ref_tick;
	logic              ext_clk;
	logic              pin_in;
	logic              pin_out;
	logic              pin_oe;
	logic              bl;
	ppm_panel_ctl_type pctl;
	ppm_mode_type      mode;
	logic [31:0]       seed;
	int                errors;
	int                num_checks;
	int                cyc = 0;
	int                w;
	logic [7:0]        t2[6] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h80, 8'h00};
	logic [7:0]        t3[6] = '{8'h10, 8'h10, 8'h20, 8'h00, 8'h00, 8'h00};
	logic [7:0]        t5[6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
	ppm_mode_type      tm[6] = '{PPM_STANDBY, PPM_SUSPEND, PPM_STANDBY, PPM_OFF, PPM_COVER, PPM_ACTIVE};
	int                tn[6] = '{512, 512, 1024, 1024, 1024, 3000};
	logic [7:0]        ra[3] = '{8'h10, 8'h20, 8'h03};

	////////////////////////////////////////////////////////////////////////////////
	// Short dividers keep a sixteenth-minute at sixteen clocks on the reference, twelve on the running external clock
	ppm_power_manager #(.DIV_REF(2), .DIV_EXT(2)) uut (
		.clk(clk), .rst_n(rst_n), .io_req(io_req), .io_rdata(io_rdata),
		.gfx_access(gfx), .kbd_activity(kbd), .ref_tick(ref_tick), .ext_clk_32k(ext_clk),
		.off_pin_in(pin_in), .off_pin_out(pin_out), .off_pin_oe(pin_oe),
		.panel_backlight_output(bl), .panel_ctl(pctl), .power_mode(mode));

	// Far side of the pins
	ppm_far_model far (
		.clk(clk), .rst_n(rst_n), .ext_run(ext_run), .drv_en(drv_en), .drv_lvl(drv_lvl),
		.off_pin_out(pin_out), .off_pin_oe(pin_oe), .ref_tick(ref_tick), .ext_clk_32k(ext_clk),
		.off_pin_in(pin_in));

	// 10 MHz clock
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	// Cycle ceiling well above the longest expected run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			errors++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic ppm_mode_type exp_force(input int b);
		exp_force = (b == 4) ? PPM_STANDBY : (b == 5) ? PPM_SUSPEND : PPM_OFF;
	endfunction

	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic mchk(input ppm_mode_type m);
		check({5'h00, mode}, {5'h00, m});
	endtask

	task automatic do_reset();
		rst_n = 1'h0;
		repeat (6) @(negedge clk);
		rst_n = 1'h1;
		@(negedge clk);
	endtask

	// One I/O cycle, held for a whole clock, then an idle clock before the next strobe
	task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d);
		io_req.wr = wr;
		io_req.rd = !wr;
		io_req.addr = a;
		io_req.wdata = d;
		@(negedge clk);
		io_req.wr = 1'h0;
		io_req.rd = 1'h0;
		@(negedge clk);
	endtask

	task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
		io(1'h1, 16'h03c4, idx);
		io(1'h1, 16'h03c5, d);
	endtask

	task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
		io(1'h1, 16'h03c4, idx);
		io(1'h0, 16'h03c5, 8'h00);
		check(io_rdata, exp);
	endtask

	task automatic act(input logic k);
		gfx = !k;
		kbd = k;
		@(negedge clk);
		gfx = 1'h0;
		kbd = 1'h0;
	endtask

	// Still active at lo cycles, target mode reached by hi
	task automatic expect_at(input ppm_mode_type m, input int lo, input int hi);
		repeat (lo) @(negedge clk);
		mchk(PPM_ACTIVE);
		for (int i = lo; i < hi && mode !== m; i++) begin
			@(negedge clk);
		end
		mchk(m);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		io_req = '0;
		gfx = 1'h0;
		kbd = 1'h0;
		ext_run = 1'h0;
		drv_en = 1'h0;
		drv_lvl = 1'h0;
		seed = 32'h8ae62745;
		errors = 0;
		num_checks = 0;
		do_reset();
		// Reset state; index d1 is not mapped and reads zero
		mchk(PPM_ACTIVE);
		check({6'h00, bl, pin_oe}, 8'h03);
		for (int i = 8'hd1; i < 8'hd6; i++) begin
			rchk(8'(i), 8'h00);
		end
		// Random register contents read back, unmapped index ignores writes
		repeat (8) begin
			seed = lfsr(seed);
			wreg(8'hd2 + 8'(seed[1:0]), seed[15:8]);
			rchk(8'hd2 + 8'(seed[1:0]), seed[15:8]);
			wreg(8'hd1, seed[23:16]);
			rchk(8'hd1, 8'h00);
		end
		// Software force bits, each left again by enabled activity
		do_reset();
		wreg(8'hd4, 8'h10);
		for (int b = 4; b < 7; b++) begin
			wreg(8'hd2, 8'h01 << b);
			@(negedge clk);
			mchk(exp_force(b));
			check({7'h00, pin_out}, {7'h00, b != 6});
			wreg(8'hd2, 8'h00);
			act(1'h0);
			@(negedge clk);
			mchk(PPM_ACTIVE);
		end
		// CRT-only system: cover-close selected together with force off
		wreg(8'hd2, 8'hc0);
		@(negedge clk);
		mchk(PPM_COVER);
		check({5'h00, bl, pctl.logic_down, pctl.crt_on}, 8'h03);
		wreg(8'hd2, 8'h44);
		@(negedge clk);
		check({4'h0, pin_out, mode}, {4'h0, 1'h1, PPM_OFF});
		// Slow refresh shows only in off mode; its rate is passed on in every mode
		wreg(8'hd5, 8'h70);
		@(negedge clk);
		check({5'h00, pctl.slow_refresh, pctl.refresh_rate}, 8'h07);
		// Shutdown pin as input in both polarities
		do_reset();
		wreg(8'hd4, 8'h10);
		wreg(8'hd2, 8'h02);
		@(negedge clk);
		check({7'h00, pin_oe}, 8'h00);
		drv_en = 1'h1;
		repeat (3) @(negedge clk);
		mchk(PPM_OFF);
		wreg(8'hd2, 8'h06);
		act(1'h0);
		@(negedge clk);
		mchk(PPM_ACTIVE);
		drv_lvl = 1'h1;
		repeat (3) @(negedge clk);
		mchk(PPM_OFF);
		// Idle and off timers, zero setting, cover-close replacing off
		for (int t = 0; t < 6; t++) begin
			do_reset();
			wreg(8'hd2, t2[t]);
			wreg(8'hd3, t3[t]);
			wreg(8'hd5, t5[t]);
			expect_at(tm[t], tn[t] - 40, tn[t] + 40);
		end
		// Activity restarts the idle count; a backlight-only enable does not
		for (int k = 0; k < 3; k++) begin
			do_reset();
			wreg(8'hd3, 8'h10);
			wreg(8'hd4, ra[k]);
			seed = lfsr(seed);
			w = 300 + int'(seed[6:0]);
			repeat (w) @(negedge clk);
			act(k == 1);
			w = (k < 2) ? 511 : 499 - w;
			expect_at(PPM_STANDBY, w - 40, w + 40);
			// Enabled activity wakes a timed standby and it stays awake
			act(k == 1);
			repeat (3) @(negedge clk);
			mchk((k < 2) ? PPM_ACTIVE : PPM_STANDBY);
		end
		// Backlight restarted late stays on into standby, then goes off
		for (int k = 0; k < 2; k++) begin
			do_reset();
			wreg(8'hd3, 8'h11);
			wreg(8'hd4, 8'h01 << k);
			repeat (420) @(negedge clk);
			act(k[0]);
			expect_at(PPM_STANDBY, 40, 130);
			check({7'h00, bl}, 8'h01);
			repeat (300) @(negedge clk);
			check({7'h00, bl}, 8'h00);
		end
		// External time base counts only while its clock runs
		do_reset();
		wreg(8'hd5, 8'h80);
		wreg(8'hd3, 8'h10);
		expect_at(PPM_ACTIVE, 1000, 1000);
		ext_run = 1'h1;
		expect_at(PPM_STANDBY, 0, 800);
		print_verdict();
	end
endmodule
